// >>> verilog/pcg_port.sv
// Eight-pin port with direction, latch, APB access and peripheral pin mux
//
// Summary of operation
// - Eight pins, each individually input or output.
// - Direction bit one tri-states the pin driver.
// - Direction bit zero drives the latch value on the pin.
// - Latch register readable; reads return latch, not pins.
// - Reset makes all eight pins inputs.
// - SPI, I2C, serial and timer oscillator override direction to output or input.
// - Direction register reads return stored contents always.
// - Second channel uses pin 1 when its select bit is one.
// - Timer oscillator on pins 0 and 1 disables digital I/O.
// - Pin 0 feeds timer counter input when direction is one.
// - Pin 2 carries first channel output or capture input.
// - Pin 1 carries second channel output or capture input.
// - Pin 3 carries SPI clock output or input.
// - Pin 3 in I2C mode carries I2C clock out or in.
// - Pin 4 feeds SPI data input when direction is one.
// - Pin 4 in I2C mode drives I2C data and feeds input.
// - Pin 5 drives SPI data output when direction is zero.
// - Pin 6 drives serial transmit; forced output in sync mode too.
// - Pin 7 feeds serial receive; sync mode data bidirectional.
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "pcg_cfg.svh"
module pcg_port #(
    parameter int PINS = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PINS-1:0] pad_in,
    output logic [PINS-1:0] pad_out,
    output logic [PINS-1:0] pad_oe,
    output logic [PINS-1:0] pin_to_periph,
    output logic timer_osc_active,
    input wire pcg_pkg::pcg_periph_out_t periph_out,
    input wire logic sync_drive_dt
);
    pcg_pkg::pcg_state_t s_q;
    pcg_pkg::pcg_state_t s_d;
    logic tosc;
    logic spi;
    logic i2c;
    logic ser;
    logic sync;
    logic [PINS-1:0] ovr_en;
    logic [PINS-1:0] ovr_val;
    logic [PINS-1:0] ovr_dir;
    logic [PINS-1:0] ovr_dir_val;
    logic [PINS-1:0] eff_dir;

    ////////////////////////////////////////////////////////////////////////
    // Peripheral override decode
    always_comb begin
        tosc = s_q.periph[`PCG_BIT_TOSC];
        spi = s_q.periph[`PCG_BIT_SPI] & ~s_q.periph[`PCG_BIT_I2C];
        i2c = s_q.periph[`PCG_BIT_I2C];
        ser = s_q.periph[`PCG_BIT_SER];
        sync = s_q.periph[`PCG_BIT_SYNC];
        ovr_en = '0;
        ovr_val = '0;
        ovr_dir = '0;
        ovr_dir_val = '0;
        if (s_q.periph[`PCG_BIT_CH2] && s_q.periph[`PCG_BIT_CH2SEL]) begin
            ovr_en[1] = 1'b1;
            ovr_val[1] = periph_out.ch2_out;
        end
        if (s_q.periph[`PCG_BIT_CH1]) begin
            ovr_en[2] = 1'b1;
            ovr_val[2] = periph_out.ch1_out;
        end
        if (spi) begin
            ovr_en[3] = 1'b1;
            ovr_val[3] = periph_out.spi_sck_out;
            ovr_en[5] = 1'b1;
            ovr_val[5] = periph_out.spi_sdo;
            ovr_dir[4] = 1'b1;
            ovr_dir_val[4] = 1'b1;
        end
        if (i2c) begin
            ovr_en[3] = 1'b1;
            ovr_val[3] = periph_out.i2c_scl_out;
            ovr_en[4] = 1'b1;
            ovr_val[4] = periph_out.i2c_sda_out;
            ovr_dir[4] = 1'b1;
            ovr_dir_val[4] = 1'b0;
        end
        if (ser) begin
            ovr_en[6] = 1'b1;
            ovr_val[6] = periph_out.ser_tx_out;
            ovr_dir[6] = 1'b1;
            ovr_dir_val[6] = 1'b0;
            if (sync) begin
                ovr_en[7] = 1'b1;
                ovr_val[7] = periph_out.ser_dt_out;
                ovr_dir[7] = 1'b1;
                ovr_dir_val[7] = ~sync_drive_dt;
            end else begin
                ovr_dir[7] = 1'b1;
                ovr_dir_val[7] = 1'b1;
            end
        end
        if (tosc) begin
            ovr_dir[1:0] = 2'b11;
            ovr_dir_val[1:0] = 2'b11;
        end
        eff_dir = (s_q.dir & ~ovr_dir) | (ovr_dir_val & ovr_dir);
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.pready = psel & ~penable;
        s_d.pslverr = 1'b0;
        s_d.prdata = '0;
        s_d.pins_smp = pad_in;
        // Setup phase: decode and prepare the answer for the access phase
        if (psel && !penable) begin
            unique case (paddr)
                `PCG_OFS_PINS: s_d.prdata = {24'h00_0000, s_q.pins_smp};
                `PCG_OFS_LATCH: s_d.prdata = {24'h00_0000, s_q.latch};
                `PCG_OFS_DIR: s_d.prdata = {24'h00_0000, s_q.dir};
                `PCG_OFS_PERIPH: s_d.prdata = {23'h00_0000, s_q.periph};
                default: s_d.pslverr = 1'b1;
            endcase
            if (pwrite) begin
                s_d.prdata = '0;
            end
        end
        // Writes land only at the completing edge of the access phase
        if (psel && penable && s_q.pready && pwrite && !s_q.pslverr) begin
            unique case (paddr)
                `PCG_OFS_PINS: s_d.latch = pwdata[7:0];
                `PCG_OFS_LATCH: s_d.latch = pwdata[7:0];
                `PCG_OFS_DIR: s_d.dir = pwdata[7:0];
                `PCG_OFS_PERIPH: s_d.periph = pwdata[`PCG_PERIPH_W-1:0];
                default: s_d.pslverr = 1'b0;
            endcase
        end
        s_d.pad_oe = ~eff_dir;
        s_d.pad_out = (s_q.latch & ~ovr_en) | (ovr_val & ovr_en);
        s_d.to_periph = pad_in & eff_dir;
        if (tosc) begin
            s_d.pad_oe[1:0] = 2'b00;
            s_d.to_periph[1:0] = 2'b00;
        end
        if (i2c) begin
            s_d.to_periph[4] = pad_in[4];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.dir <= `PCG_RST_DIR;
            s_q.latch <= `PCG_RST_LATCH;
            s_q.periph <= {`PCG_RST_CH2SEL, `PCG_RST_PERIPH};
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign pad_out = s_q.pad_out;
    assign pad_oe = s_q.pad_oe;
    assign pin_to_periph = s_q.to_periph;
    assign timer_osc_active = s_q.periph[`PCG_BIT_TOSC];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_RESET_INPUTS: assert property (@(posedge mclk)
        $rose(rst_n) |-> s_q.pad_oe == 8'h00)
        else $error("pins not inputs after reset");

    AST_RESET_DIR: assert property (@(posedge mclk)
        $rose(rst_n) |-> s_q.dir == `PCG_RST_DIR)
        else $error("direction not all inputs after reset");

    AST_RESET_IDLE: assert property (@(posedge mclk)
        $rose(rst_n) |-> !pready)
        else $error("ready high after reset");

    AST_DIR_ONE_TRISTATE: assert property (@(posedge mclk) disable iff (!rst_n)
        (eff_dir[5] && !tosc) |=> !pad_oe[5])
        else $error("driver enabled with direction one");

    AST_DIR0_TRISTATE: assert property (@(posedge mclk) disable iff (!rst_n)
        eff_dir[0] |=> !pad_oe[0])
        else $error("pin 0 driven with direction one");

    AST_DIR3_TRISTATE: assert property (@(posedge mclk) disable iff (!rst_n)
        eff_dir[3] |=> !pad_oe[3])
        else $error("pin 3 driven with direction one");

    AST_DIR7_TRISTATE: assert property (@(posedge mclk) disable iff (!rst_n)
        eff_dir[7] |=> !pad_oe[7])
        else $error("pin 7 driven with direction one");

    AST_OE_FOLLOWS_DIR: assert property (@(posedge mclk) disable iff (!rst_n)
        !tosc |=> pad_oe == ~$past(eff_dir))
        else $error("enables do not follow direction");

    AST_LATCH_DRIVE: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_q.dir[0] == 1'b0 && !tosc) |=> (pad_oe[0] && pad_out[0] == $past(s_q.latch[0])))
        else $error("latch not driven");

    AST_LATCH_DRIVE_P5: assert property (@(posedge mclk) disable iff (!rst_n)
        (!s_q.dir[5] && !spi) |=> (pad_oe[5] && pad_out[5] == $past(s_q.latch[5])))
        else $error("pin 5 latch not driven");

    AST_LATCH_DRIVE_P6: assert property (@(posedge mclk) disable iff (!rst_n)
        (!s_q.dir[6] && !ser) |=> (pad_oe[6] && pad_out[6] == $past(s_q.latch[6])))
        else $error("pin 6 latch not driven");

    AST_OUT_FOLLOWS_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_q.periph[7:0] == 8'h00) |=> pad_out == $past(s_q.latch))
        else $error("drive value differs from latch");

    AST_LATCH_READ: assert property (@(posedge mclk) disable iff (!rst_n)
        (psel && !pready && !pwrite && paddr == `PCG_OFS_LATCH)
        |=> prdata[7:0] == $past(s_q.latch))
        else $error("latch read wrong");

    AST_LATCH_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
        (psel && penable && pready && pwrite && !pslverr && paddr == `PCG_OFS_LATCH)
        |=> s_q.latch == $past(pwdata[7:0]))
        else $error("latch write lost");

    AST_LATCH_KEEP: assert property (@(posedge mclk) disable iff (!rst_n)
        !(psel && penable && pwrite) |=> s_q.latch == $past(s_q.latch))
        else $error("latch changed without write");

    AST_UNMAPPED_ERR: assert property (@(posedge mclk) disable iff (!rst_n)
        (psel && !penable && paddr > `PCG_OFS_PERIPH) |=> (pslverr && prdata == 32'h0000_0000))
        else $error("unmapped access not refused");

    AST_READY_PULSE: assert property (@(posedge mclk) disable iff (!rst_n)
        (pready && penable) |=> !pready)
        else $error("ready stuck high");

    AST_PERIPH_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
        (psel && penable && pready && pwrite && !pslverr && paddr == `PCG_OFS_PERIPH)
        |=> s_q.periph == $past(pwdata[8:0]))
        else $error("peripheral control write lost");

    AST_SPI_DIR_OVR: assert property (@(posedge mclk) disable iff (!rst_n)
        spi |=> !pad_oe[4])
        else $error("SPI data pin not forced input");

    AST_SER_DIR_OVR: assert property (@(posedge mclk) disable iff (!rst_n)
        ser |=> pad_oe[6])
        else $error("serial pin not forced output");

    AST_DIR_READ: assert property (@(posedge mclk) disable iff (!rst_n)
        (psel && !pready && !pwrite && paddr == `PCG_OFS_DIR)
        |=> prdata[7:0] == $past(s_q.dir))
        else $error("direction read wrong");

    AST_DIR_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
        (psel && penable && pready && pwrite && !pslverr && paddr == `PCG_OFS_DIR)
        |=> s_q.dir == $past(pwdata[7:0]))
        else $error("direction write lost");

    AST_DIR_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
        !(psel && penable && pwrite) |=> s_q.dir == $past(s_q.dir))
        else $error("direction changed by override");

    AST_CH2_PIN_SEL: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_q.periph[`PCG_BIT_CH2] && s_q.periph[`PCG_BIT_CH2SEL] && !tosc && !s_q.dir[1])
        |=> (pad_oe[1] && pad_out[1] == $past(periph_out.ch2_out)))
        else $error("second channel not on pin 1");

    AST_CH2_NO_SEL: assert property (@(posedge mclk) disable iff (!rst_n)
        !s_q.periph[`PCG_BIT_CH2SEL] |=> pad_out[1] == $past(s_q.latch[1]))
        else $error("second channel on pin 1 while deselected");

    AST_TOSC_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
        tosc |=> pad_oe[1:0] == 2'b00)
        else $error("oscillator pins driven");

    AST_TOSC_NO_INPUT: assert property (@(posedge mclk) disable iff (!rst_n)
        tosc |=> pin_to_periph[1:0] == 2'b00)
        else $error("oscillator pins forwarded");

    AST_COUNTER_IN: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_q.dir[0] && !tosc) |=> pin_to_periph[0] == $past(pad_in[0]))
        else $error("counter input not forwarded");

    AST_COUNTER_BLOCK: assert property (@(posedge mclk) disable iff (!rst_n)
        !s_q.dir[0] |=> !pin_to_periph[0])
        else $error("counter input forwarded while output");

    AST_CH1_OUT: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_q.periph[`PCG_BIT_CH1] && !s_q.dir[2]) |=> pad_out[2] == $past(periph_out.ch1_out))
        else $error("first channel output lost");

    AST_CH1_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_n)
        s_q.dir[2] |=> pin_to_periph[2] == $past(pad_in[2]))
        else $error("first channel capture lost");

    AST_CH2_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_n)
        (s_q.dir[1] && !tosc) |=> pin_to_periph[1] == $past(pad_in[1]))
        else $error("second channel capture lost");

    AST_SPI_SCK_OUT: assert property (@(posedge mclk) disable iff (!rst_n)
        (spi && !s_q.dir[3]) |=> (pad_oe[3] && pad_out[3] == $past(periph_out.spi_sck_out)))
        else $error("SPI clock output lost");

    AST_SPI_SCK_IN: assert property (@(posedge mclk) disable iff (!rst_n)
        s_q.dir[3] |=> pin_to_periph[3] == $past(pad_in[3]))
        else $error("SPI clock input lost");

    AST_I2C_SCL_OUT: assert property (@(posedge mclk) disable iff (!rst_n)
        (i2c && !s_q.dir[3]) |=> pad_out[3] == $past(periph_out.i2c_scl_out))
        else $error("I2C clock output lost");

    AST_SPI_SDI: assert property (@(posedge mclk) disable iff (!rst_n)
        spi |=> pin_to_periph[4] == $past(pad_in[4]))
        else $error("SPI data input lost");

    AST_I2C_SDA_OUT: assert property (@(posedge mclk) disable iff (!rst_n)
        i2c |=> (pad_oe[4] && pad_out[4] == $past(periph_out.i2c_sda_out)))
        else $error("I2C data output lost");

    AST_I2C_SDA_IN: assert property (@(posedge mclk) disable iff (!rst_n)
        i2c |=> pin_to_periph[4] == $past(pad_in[4]))
        else $error("I2C data input lost");

    AST_SPI_SDO: assert property (@(posedge mclk) disable iff (!rst_n)
        (spi && !s_q.dir[5]) |=> pad_out[5] == $past(periph_out.spi_sdo))
        else $error("SPI data output lost");

    AST_SER_TX: assert property (@(posedge mclk) disable iff (!rst_n)
        ser |=> pad_out[6] == $past(periph_out.ser_tx_out))
        else $error("serial transmit lost");

    AST_SER_RX: assert property (@(posedge mclk) disable iff (!rst_n)
        (ser && !sync) |=> (!pad_oe[7] && pin_to_periph[7] == $past(pad_in[7])))
        else $error("serial receive lost");

    AST_SYNC_DT_OUT: assert property (@(posedge mclk) disable iff (!rst_n)
        (ser && sync && sync_drive_dt) |=> (pad_oe[7] && pad_out[7] == $past(periph_out.ser_dt_out)))
        else $error("sync data output lost");

    AST_SYNC_DT_IN: assert property (@(posedge mclk) disable iff (!rst_n)
        (ser && sync && !sync_drive_dt) |=> !pad_oe[7])
        else $error("sync data pin driven while receiving");

    AST_PIN_READ: assert property (@(posedge mclk) disable iff (!rst_n)
        (psel && !pready && !pwrite && paddr == `PCG_OFS_PINS)
        |=> prdata[7:0] == $past(s_q.pins_smp))
        else $error("pin read wrong");

    AST_PINS_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
        (psel && penable && pready && pwrite && !pslverr && paddr == `PCG_OFS_PINS)
        |=> s_q.latch == $past(pwdata[7:0]))
        else $error("port write did not reach latch");

    AST_PIN_SAMPLE: assert property (@(posedge mclk) disable iff (!rst_n)
        1'b1 |=> s_q.pins_smp == $past(pad_in))
        else $error("pin levels not sampled");

endmodule : pcg_port
`default_nettype wire

// >>> verilog/pcg_cfg.svh
// Register offsets, reset values and field positions of the port block
`ifndef PCG_CFG_SVH
`define PCG_CFG_SVH
`define PCG_OFS_PINS 12'h000
`define PCG_OFS_LATCH 12'h004
`define PCG_OFS_DIR 12'h008
`define PCG_OFS_PERIPH 12'h00C
`define PCG_RST_DIR 8'hFF
`define PCG_RST_LATCH 8'h00
`define PCG_RST_PERIPH 8'h00
`define PCG_RST_CH2SEL 1'b1
`define PCG_BIT_TOSC 0
`define PCG_BIT_SPI 1
`define PCG_BIT_I2C 2
`define PCG_BIT_SER 3
`define PCG_BIT_SYNC 4
`define PCG_BIT_CH1 5
`define PCG_BIT_CH2 6
`define PCG_BIT_I2CST 7
`define PCG_BIT_CH2SEL 8
`define PCG_PERIPH_W 9
`endif

// >>> verilog/pcg_pkg.sv
// Types of the port block
package pcg_pkg;
    typedef struct packed {
        logic [7:0] latch;
        logic [7:0] dir;
        logic [8:0] periph;
        logic [7:0] pins_smp;
        logic [7:0] pad_out;
        logic [7:0] pad_oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [7:0] to_periph;
    } pcg_state_t;
    typedef struct packed {
        logic ch1_out;
        logic ch2_out;
        logic spi_sck_out;
        logic spi_sdo;
        logic i2c_scl_out;
        logic i2c_sda_out;
        logic ser_tx_out;
        logic ser_dt_out;
    } pcg_periph_out_t;
endpackage : pcg_pkg

// >>> testbench/pcg_pad_model.sv
// Pad-side circuitry: reads back driven pins, else external level
`timescale 1ns/10ps
`default_nettype none
module pcg_pad_model (
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pad_in
);
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pad_in[i] = pad_oe[i] ? pad_out[i] : ext_level[i];
        end
    end
endmodule : pcg_pad_model
`default_nettype wire

// >>> testbench/pcg_port_tb_top.sv
// Self-checking bench of the port block
`timescale 1ns/10ps
`default_nettype none
module pcg_port_tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] pad_in;
    logic [7:0] pad_out;
    logic [7:0] pad_oe;
    logic [7:0] ext_level = 8'h5a;
    logic osc_on;
    logic [7:0] to_periph;
    logic sdt = 1'b0;
    pcg_pkg::pcg_periph_out_t periph_out = '0;
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic er;
    pcg_port u_pcg_port (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pin_to_periph(to_periph), .timer_osc_active(osc_on), .periph_out(periph_out),
        .sync_drive_dt(sdt));
    pcg_pad_model u_pcg_pad_model (.pad_out(pad_out), .pad_oe(pad_oe),
        .ext_level(ext_level), .pad_in(pad_in));
    initial begin
        forever #2 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles > 2000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // One APB transfer, entered just after a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        // Look mid-cycle; answer stands through the completing edge
        @(negedge mclk);
        while (pready !== 1'b1) begin
            @(posedge mclk);
            @(negedge mclk);
        end
        rd = prdata;
        er = pslverr;
        @(posedge mclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask : apb
    task automatic settle();
        repeat (3) @(posedge mclk);
    endtask : settle
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        apb(1'b0, 12'h008, 32'h0);
        chk("dir", rd, 32'h0000_00ff);
        chk("oe", {24'h0, pad_oe}, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk("latch", rd, 32'h0);
        chk("fwd", {24'h0, to_periph}, 32'h0000_005a);
    endtask : t_reset
    task automatic t_drive();
        apb(1'b1, 12'h000, 32'h0000_00a5);
        apb(1'b1, 12'h008, 32'h0000_00f0);
        settle();
        chk("oe", {24'h0, pad_oe}, 32'h0000_000f);
        chk("out", {28'h0, pad_out[3:0]}, 32'h0000_0005);
        apb(1'b0, 12'h000, 32'h0);
        chk("pins", rd, 32'h0000_0055);
        apb(1'b0, 12'h004, 32'h0);
        chk("latch", rd, 32'h0000_00a5);
        apb(1'b1, 12'h008, 32'h0000_0000);
    endtask : t_drive
    task automatic t_periph();
        periph_out <= pcg_pkg::pcg_periph_out_t'(8'h20);
        apb(1'b1, 12'h00c, 32'h0000_0102);
        settle();
        chk("spi out", {24'h0, pad_out}, 32'h0000_008d);
        chk("spi oe", {24'h0, pad_oe}, 32'h0000_00ef);
        apb(1'b0, 12'h008, 32'h0);
        chk("dir", rd, 32'h0);
        periph_out <= pcg_pkg::pcg_periph_out_t'(8'h40);
        apb(1'b1, 12'h00c, 32'h0000_0160);
        settle();
        chk("ccp out", {24'h0, pad_out}, 32'h0000_00a3);
        apb(1'b1, 12'h00c, 32'h0000_0101);
        settle();
        chk("osc oe", {24'h0, pad_oe}, 32'h0000_00fc);
        chk("osc", {31'h0, osc_on}, 32'h1);
        chk("osc fwd", {24'h0, to_periph}, 32'h0);
    endtask : t_periph
    task automatic t_serial();
        sdt <= 1'b1;
        periph_out <= pcg_pkg::pcg_periph_out_t'(8'h03);
        apb(1'b1, 12'h008, 32'h0000_00ff);
        apb(1'b1, 12'h00c, 32'h0000_0018);
        settle();
        chk("ser oe", {24'h0, pad_oe}, 32'h0000_00c0);
        chk("ser out", {24'h0, pad_out}, 32'h0000_00e5);
        sdt <= 1'b0;
        settle();
        chk("sync in oe", {24'h0, pad_oe}, 32'h0000_0040);
        periph_out <= pcg_pkg::pcg_periph_out_t'(8'h0c);
        apb(1'b1, 12'h00c, 32'h0000_0104);
        settle();
        chk("i2c oe", {24'h0, pad_oe}, 32'h0000_0010);
        chk("i2c out", {24'h0, pad_out}, 32'h0000_00bd);
        chk("i2c fwd", {24'h0, to_periph}, 32'h0000_005a);
    endtask : t_serial
    task automatic t_unmapped();
        apb(1'b0, 12'h010, 32'h0);
        chk("err", {31'h0, er}, 32'h1);
        chk("data", rd, 32'h0);
    endtask : t_unmapped
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_drive();
        t_periph();
        t_serial();
        t_unmapped();
        report_and_stop();
    end
endmodule : pcg_port_tb_top
`default_nettype wire
